// ---- rtl/acr_top.sv ----
// Converter sample timing, result formatting and register slave
// Functional notes
// - Sampling lasts 2 plus delay count plus length count converter clocks.
// - A job takes 2 start-up clocks, then per sample 16 plus delay plus length converter clocks and 2 clocks.
// - After enable, sampling is held off for the init hold-off count.
// - Each finished conversion or accumulation lands in one 16-bit result register.
// - Single-ended results are unsigned, differential results are sign extended.
// - Codes span 0..4095 or -2048..2047 at 12 bits and 0..1023 or -512..511 at 10 bits.
// - Single-ended 12-bit codes saturate to all ones above reference and zero below ground.
// - Differential 12-bit codes saturate to 2047 and -2048.
// - Results are right aligned unless left align puts the top eight of the 12 code bits in the high byte, also at 10-bit resolution.
// - The selected number of samples is summed, dropping low bits beyond 16 samples.
// - For 1 to 16 samples the value takes 12 to 16 bits, zero filled by alignment, sign filled when differential and right aligned.
// - Truncated differential sums fill all 16 bits whatever the alignment.
// - Each sample is held 2 plus delay plus length converter clocks then converted over 14.
// - The accumulator clears whenever a new accumulated conversion starts.
// - The result ready flag sets on completion whether or not it is unmasked.
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`include "acr_cfg.svh"
module acr_top #(
  parameter int ACC_W = 23
) (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [`ACR_ADDR_W-1:0]  avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  output logic                         irq_o,
  output logic                         busy_o
);
  acr_pkg::acr_state_s s_q;
  acr_pkg::acr_state_s s_d;

  logic        adc_tick;
  logic        wr_hit;
  logic        rd_hit;
  logic [11:0] code;
  logic [15:0] fmt;
  logic [7:0]  n_smp;
  logic [8:0]  samp_len;
  logic [22:0] sum;

  // Converter clock enable; the prescaler is held at zero while idle
  assign adc_tick = (s_q.presc_cnt == s_q.ctrl.presc);

  // Sample code: 10-bit resolution keeps the low ten bits, sign extended when differential
  always_comb begin
    code = s_q.sample;
    if (s_q.ctrl.diff) begin
      if (s_q.ctrl.res10) begin
        code = {{2{s_q.sample[9]}}, s_q.sample[9:0]};
      end
    end else if (s_q.ctrl.res10) begin
      code = {2'b00, s_q.sample[9:0]};
    end
  end

  assign samp_len = 9'(`ACR_HOLD_ADC) + 9'(s_q.tim.dly)
                    + 9'(s_q.tim.len);
  assign n_smp    = 8'(1) << s_q.ctrl.acc_sel;

  // Signed or unsigned extension of the code into the accumulator
  assign sum = s_q.ctrl.diff
               ? s_q.acc + {{11{code[11]}}, code}
               : s_q.acc + {11'h000, code};

  // Result format from the finished sum
  always_comb begin
    fmt = 16'h0000;
    case (s_q.ctrl.acc_sel)
      3'd0: fmt = s_q.ctrl.left ? {s_q.acc[11:0], 4'h0}
                 : (s_q.ctrl.diff ? {{4{s_q.acc[11]}}, s_q.acc[11:0]}
                                  : {4'h0, s_q.acc[11:0]});
      3'd1: fmt = s_q.ctrl.left ? {s_q.acc[12:0], 3'h0}
                 : (s_q.ctrl.diff ? {{3{s_q.acc[12]}}, s_q.acc[12:0]}
                                  : {3'h0, s_q.acc[12:0]});
      3'd2: fmt = s_q.ctrl.left ? {s_q.acc[13:0], 2'h0}
                 : (s_q.ctrl.diff ? {{2{s_q.acc[13]}}, s_q.acc[13:0]}
                                  : {2'h0, s_q.acc[13:0]});
      3'd3: fmt = s_q.ctrl.left ? {s_q.acc[14:0], 1'b0}
                 : (s_q.ctrl.diff ? {s_q.acc[14], s_q.acc[14:0]}
                                  : {1'b0, s_q.acc[14:0]});
      3'd4: fmt = s_q.acc[15:0];
      3'd5: fmt = s_q.acc[16:1];
      3'd6: fmt = s_q.acc[17:2];
      3'd7: fmt = s_q.acc[18:3];
      default: fmt = 16'h0000;
    endcase
  end

  assign wr_hit = avs_write_i;
  assign rd_hit = avs_read_i;

  always_comb begin
    s_d = s_q;
    // Prescaler runs only while a conversion is active
    if (s_q.busy && s_q.state != acr_pkg::ACR_START) begin
      s_d.presc_cnt = adc_tick ? 8'h00 : s_q.presc_cnt + 8'h01;
    end else begin
      s_d.presc_cnt = 8'h00;
    end

    case (s_q.state)
      acr_pkg::ACR_IDLE: begin
        // Hold-off runs once per enable; re-entering it would refuse starts
        if (s_q.ctrl.enable && !s_q.init_done) begin
          s_d.state   = acr_pkg::ACR_INIT;
          s_d.cyc_cnt = 9'h000;
        end
      end
      acr_pkg::ACR_INIT: begin
        // Hold-off counted on the raw clock; INIT lasts init count plus one clocks, so a count of 0 still takes one
        if (!s_q.ctrl.enable) begin
          s_d.state = acr_pkg::ACR_IDLE;
        end else if (s_q.cyc_cnt >= 9'(s_q.tim.init)) begin
          s_d.init_done = 1'b1;
          s_d.state     = acr_pkg::ACR_IDLE;
        end else begin
          s_d.cyc_cnt = s_q.cyc_cnt + 9'h001;
        end
      end
      acr_pkg::ACR_START: begin
        if (s_q.cyc_cnt == 9'(`ACR_STARTUP_PER - 1)) begin
          s_d.state   = acr_pkg::ACR_SAMPLE;
          s_d.cyc_cnt = 9'h000;
        end else begin
          s_d.cyc_cnt = s_q.cyc_cnt + 9'h001;
        end
      end
      acr_pkg::ACR_SAMPLE: begin
        if (adc_tick) begin
          if (s_q.cyc_cnt == samp_len - 9'h001) begin
            s_d.state   = acr_pkg::ACR_CONV;
            s_d.cyc_cnt = 9'h000;
          end else begin
            s_d.cyc_cnt = s_q.cyc_cnt + 9'h001;
          end
        end
      end
      acr_pkg::ACR_CONV: begin
        // Whole converter clocks: the half-clock count of 27 halved to 13, ending on the 14th tick
        if (adc_tick) begin
          if (s_q.cyc_cnt == 9'(`ACR_CONV_HALF_ADC / 2)) begin
            s_d.state   = acr_pkg::ACR_FORMAT;
            s_d.cyc_cnt = 9'h000;
            s_d.acc     = sum;
          end else begin
            s_d.cyc_cnt = s_q.cyc_cnt + 9'h001;
          end
        end
      end
      acr_pkg::ACR_FORMAT: begin
        if (s_q.cyc_cnt == 9'(`ACR_FORMAT_PER - 1)) begin
          s_d.cyc_cnt = 9'h000;
          if (s_q.smp_cnt == n_smp - 8'h01) begin
            s_d.result = fmt;
            s_d.status = 1'b1;
            s_d.busy   = 1'b0;
            s_d.state  = acr_pkg::ACR_IDLE;
          end else begin
            s_d.smp_cnt = s_q.smp_cnt + 8'h01;
            s_d.state   = acr_pkg::ACR_SAMPLE;
          end
        end else begin
          s_d.cyc_cnt = s_q.cyc_cnt + 9'h001;
        end
      end
      default: s_d.state = acr_pkg::ACR_IDLE;
    endcase

    if (!s_q.ctrl.enable) begin
      s_d.init_done = 1'b0;
    end

    // Register writes; config changes mid-job give undefined results
    if (wr_hit && avs_byteenable_i[0]) begin
      case (avs_address_i)
        `ACR_OFF_CTRL: begin
          s_d.ctrl.enable  = avs_writedata_i[`ACR_CTRL_ENABLE];
          s_d.ctrl.diff    = avs_writedata_i[`ACR_CTRL_DIFF];
          s_d.ctrl.left    = avs_writedata_i[`ACR_CTRL_LEFT];
          s_d.ctrl.res10   = avs_writedata_i[`ACR_CTRL_RES10];
          s_d.ctrl.acc_sel = avs_writedata_i[`ACR_CTRL_ACC_LSB +: 3];
          s_d.ctrl.presc   = avs_writedata_i[`ACR_CTRL_PRESC_LSB +: 8];
        end
        `ACR_OFF_TIMING: begin
          s_d.tim.dly  = avs_writedata_i[`ACR_TIM_DLY_LSB +: 4];
          s_d.tim.len  = avs_writedata_i[`ACR_TIM_LEN_LSB +: 8];
          s_d.tim.init = avs_writedata_i[`ACR_TIM_INIT_LSB +: 8];
        end
        `ACR_OFF_SAMPLE_IN: begin
          // Saturation flags stand in for the analog comparator result
          if (avs_writedata_i[`ACR_SIN_OVER]) begin
            s_d.sample = s_q.ctrl.diff ? 12'h7ff : 12'hfff;
          end else if (avs_writedata_i[`ACR_SIN_UNDER]) begin
            s_d.sample = s_q.ctrl.diff ? 12'h800 : 12'h000;
          end else begin
            s_d.sample = avs_writedata_i[11:0];
          end
        end
        `ACR_OFF_COMMAND: begin
          if (avs_writedata_i[`ACR_CMD_START] && !s_q.busy
              && s_q.init_done && s_q.state == acr_pkg::ACR_IDLE) begin
            s_d.busy    = 1'b1;
            s_d.state   = acr_pkg::ACR_START;
            s_d.cyc_cnt = 9'h000;
            s_d.smp_cnt = 8'h00;
            s_d.acc     = '0;
          end
        end
        `ACR_OFF_MASK: s_d.mask = avs_writedata_i[0];
        default: ;
      endcase
    end

    // Read data is registered; one wait state on every read
    s_d.rd_pend = rd_hit && !s_q.rd_pend;
    if (rd_hit && !s_q.rd_pend) begin
      case (avs_address_i)
        `ACR_OFF_CTRL: s_d.rdata = {16'h0000, s_q.ctrl.presc, 1'b0,
                                    s_q.ctrl.acc_sel, s_q.ctrl.res10,
                                    s_q.ctrl.left, s_q.ctrl.diff,
                                    s_q.ctrl.enable};
        `ACR_OFF_TIMING: s_d.rdata = {12'h000, s_q.tim.init,
                                      s_q.tim.len, s_q.tim.dly};
        `ACR_OFF_COMMAND: s_d.rdata = {31'h0, s_q.busy};
        `ACR_OFF_SAMPLE_IN: s_d.rdata = {20'h00000, s_q.sample};
        `ACR_OFF_RESULT: s_d.rdata = {16'h0000, s_q.result};
        `ACR_OFF_STATUS: s_d.rdata = {30'h0, s_q.init_done, s_q.status};
        `ACR_OFF_MASK: s_d.rdata = {31'h0, s_q.mask};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Read clears only a flag it returned; a later completion wins
    if (s_q.rd_pend && avs_address_i == `ACR_OFF_STATUS && s_q.rdata[0]
        && !(s_q.state == acr_pkg::ACR_FORMAT
        && s_d.state == acr_pkg::ACR_IDLE)) begin
      s_d.status = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q       <= '0;
      s_q.state <= acr_pkg::ACR_IDLE;
      s_q.ctrl  <= acr_pkg::acr_ctrl_s'(15'(`ACR_CTRL_RESET));
      s_q.tim   <= acr_pkg::acr_timing_s'(20'(`ACR_TIMING_RESET));
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = avs_read_i && !s_q.rd_pend;
  assign irq_o             = s_q.status && s_q.mask;
  assign busy_o            = s_q.busy;
endmodule

// ---- rtl/acr_cfg.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
`define ACR_ADDR_W          4
`define ACR_OFF_CTRL        4'h0
`define ACR_OFF_TIMING      4'h1
`define ACR_OFF_COMMAND     4'h2
`define ACR_OFF_SAMPLE_IN   4'h3
`define ACR_OFF_RESULT      4'h4
`define ACR_OFF_STATUS      4'h5
`define ACR_OFF_MASK        4'h6
`define ACR_CTRL_ENABLE     0
`define ACR_CTRL_DIFF       1
`define ACR_CTRL_LEFT       2
`define ACR_CTRL_RES10      3
`define ACR_CTRL_ACC_LSB    4
`define ACR_CTRL_PRESC_LSB  8
`define ACR_TIM_DLY_LSB     0
`define ACR_TIM_LEN_LSB     4
`define ACR_TIM_INIT_LSB    12
`define ACR_CMD_START       0
`define ACR_SIN_OVER        12
`define ACR_SIN_UNDER       13
`define ACR_STARTUP_PER     2
`define ACR_HOLD_ADC        2
`define ACR_CONV_HALF_ADC   27
`define ACR_FORMAT_PER      2
`define ACR_CTRL_RESET      32'h0000_0000
`define ACR_TIMING_RESET    32'h0000_0000
`endif

// ---- rtl/acr_pkg.sv ----
// Types shared by the converter control block
package acr_pkg;
  typedef enum logic [2:0] {
    ACR_IDLE   = 3'b000,
    ACR_INIT   = 3'b001,
    ACR_START  = 3'b011,
    ACR_SAMPLE = 3'b010,
    ACR_CONV   = 3'b110,
    ACR_FORMAT = 3'b111
  } acr_state_e;

  typedef struct packed {
    logic        enable;
    logic        diff;
    logic        left;
    logic        res10;
    logic [2:0]  acc_sel;
    logic [7:0]  presc;
  } acr_ctrl_s;

  typedef struct packed {
    logic [3:0]  dly;
    logic [7:0]  len;
    logic [7:0]  init;
  } acr_timing_s;

  typedef struct packed {
    acr_state_e  state;
    acr_ctrl_s   ctrl;
    acr_timing_s tim;
    logic        init_done;
    logic        busy;
    logic [7:0]  presc_cnt;
    logic [8:0]  cyc_cnt;
    logic [7:0]  smp_cnt;
    logic [22:0] acc;
    logic [15:0] result;
    logic [11:0] sample;
    logic        status;
    logic        mask;
    logic        rd_pend;
    logic [31:0] rdata;
  } acr_state_s;
endpackage

// ---- dv/acr_top_chk.sv ----
// Port-level assertions for the converter control block
module acr_chk (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        irq_o,
  input wire logic        busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run_q;
  // Busy length counter, so a job shorter than one sample shows up
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !busy_o) run_q <= 16'h0000;
    else run_q <= run_q + 16'h0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rd_wait; $rose(avs_read_i) |-> avs_waitrequest_o; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read not held");
  property p_rd_done;
    avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read stalls");
  property p_wr_free; avs_write_i |-> !avs_waitrequest_o; endproperty
  a_wr_free: assert property (p_wr_free) else $error("write stalls");
  property p_unmap;
    avs_read_i && !avs_waitrequest_o && avs_address_i > 4'h6
      |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
  property p_busy_len; $fell(busy_o) |-> run_q >= 16'h0014; endproperty
  a_busy_len: assert property (p_busy_len) else $error("job too short");
  property p_busy_cause;
    $rose(busy_o) |-> $past(avs_write_i) && $past(avs_address_i) == 4'h2;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy unasked");
  property p_irq_cause; $rose(irq_o) |-> $past(busy_o) || $past(avs_write_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
  property p_irq_clr;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h5 && !busy_o
      && avs_readdata_o[0] |=> !irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
endmodule
bind acr_top acr_chk u_acr_chk (.clk_i, .sys_rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o,
  .busy_o);

// ---- dv/tb_acr_top.sv ----
// Self-checking bench for the converter control block
module tb_acr_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_o;
  logic        busy_o;
  logic [31:0] q;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          bcnt = 0;
  localparam logic [31:0] SAT [4] = '{32'h0fff, 32'h0, 32'h07ff, 32'hf800};
  always #50 clk_i = ~clk_i;
  acr_top u_acr_top (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf),
    .avs_readdata_o, .avs_waitrequest_o, .irq_o, .busy_o);
  // Job length in clocks, restarted by each command write
  always @(posedge clk_i) begin
    if (avs_write_i && avs_address_i == 4'h2) bcnt <= 0;
    else if (busy_o) bcnt <= bcnt + 1;
  end
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle; request held until waitrequest is seen low at an edge
  task automatic acc(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) begin
        if (rd) q = avs_readdata_o;
        break;
      end
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n == 20) begin
      mismatches++;
      print_verdict;
    end
    @(posedge clk_i);
  endtask
  task automatic run(input logic [31:0] ctrl, input logic [13:0] code);
    int n;
    acc(1'b0, 4'h0, ctrl);
    acc(1'b0, 4'h3, {18'h0, code});
    acc(1'b0, 4'h2, 32'h1);
    chk({31'h0, busy_o}, 32'h1);
    for (n = 0; n < 4000; n++) begin
      @(negedge clk_i);
      if (busy_o === 1'b0) break;
    end
    if (n == 4000) begin
      mismatches++;
      print_verdict;
    end
    @(posedge clk_i);
    acc(1'b1, 4'h4, 32'h0);
  endtask
  function automatic logic [31:0] fmt(logic dif, logic lft, int k,
                                      logic [11:0] c);
    logic signed [31:0] s;
    s = dif ? {{20{c[11]}}, c} : {20'h0, c};
    s = s <<< k;
    if (k > 4) s = s >>> (k - 4);
    else if (lft) s = s <<< (4 - k);
    return {16'h0, s[15:0]};
  endfunction
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    acc(1'b0, 4'h1, 32'h0002_0021);
    acc(1'b0, 4'h0, 32'h1);
    acc(1'b0, 4'h2, 32'h1);
    acc(1'b1, 4'h2, 32'h0);
    chk({31'h0, q[0]}, 32'h0);
    acc(1'b1, 4'h5, 32'h0);
    chk({31'h0, q[1]}, 32'h0);
    repeat (40) @(posedge clk_i);
    acc(1'b1, 4'h5, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    $display("hold-off test done");
    for (int d = 0; d < 2; d++) begin
      for (int l = 0; l < 2; l++) begin
        for (int k = 0; k < 8; k++) begin
          run({24'h0, 1'b0, 3'(k), 1'b0, 1'(l), 1'(d), 1'b1},
              d ? 14'h0c35 : 14'h0ab7);
          chk({16'h0, q[15:0]}, fmt(d, l, k, d ? 12'hc35 : 12'hab7));
          chk(bcnt, 32'(2 + (21 << k)));
        end
      end
    end
    $display("format test done");
    acc(1'b0, 4'h1, 32'h0002_0035);
    run(32'h0000_0101, 14'h0100);
    chk(bcnt, 32'd52);
    chk(q, 32'h0100);
    for (int i = 0; i < 4; i++) begin
      run({30'h0, i[1], 1'b1}, i[0] ? 14'h2555 : 14'h1555);
      chk({16'h0, q[15:0]}, SAT[i]);
    end
    $display("clip test done");
    acc(1'b1, 4'h5, 32'h0);
    run(32'h1, 14'h0010);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    acc(1'b1, 4'h5, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    acc(1'b1, 4'h5, 32'h0);
    chk({31'h0, q[0]}, 32'h0);
    acc(1'b0, 4'h6, 32'h1);
    run(32'h1, 14'h0010);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    acc(1'b1, 4'h5, 32'h0);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    $display("interrupt test done");
    acc(1'b0, 4'h4, 32'h1234);
    acc(1'b1, 4'h4, 32'h0);
    chk(q, 32'h0010);
    acc(1'b0, 4'hf, 32'h5a5a);
    acc(1'b1, 4'hf, 32'h0);
    chk(q, 32'h0);
    $display("register test done");
    print_verdict;
  end
endmodule
